/* verilog/sprc_pkg.sv */
// Constants and enumerations for the serial/parallel register chain.
// Assumes a single core clock domain; the serial link is sampled as plain inputs.
// Operation
// - Four 8-bit shift registers form one 32-bit chain under instruction control.
// - First two-way port has eight bits, an output latch, tied to input-end register.
// - Input-end register loads from accumulator pair, serial data or ROM immediate.
// - First port's pins are read into accumulator and auxiliary register together.
// - Port transfer instructions move all eight bits at once, both two-way ports.
// - Second register works like first, serial input from first register's LSB.
// - Second port's pins reach the auxiliary register four bits per transfer.
// - Third port output-only with latch; its register shifts in second's LSB.
// - Fourth port output-only; its register shifts in third's LSB, drives serial out.
// - Each port's eight pins can be copied into its chain register.
// - Two-way ports drive, or take pins in by port transfer, only after direction is set.
// - While shifting, a chosen 0 or 1 control bit enters the input-end MSB.
// - Serial out from output-end LSB on DATA; received bits enter input-end MSB.
// - Shift clock floats idle; driven when sending, supplied by peer when receiving.
`default_nettype none
package sprc_pkg;
  localparam int REG_W   = 8;
  localparam int NUM_REG = 4;
  localparam int CHAIN_W = REG_W * NUM_REG;
  localparam int NIB_W   = 4;
  // Register indices along the chain
  localparam logic [1:0] IDX_Q = 2'h0;
  localparam logic [1:0] IDX_R = 2'h1;
  localparam logic [1:0] IDX_S = 2'h2;
  localparam logic [1:0] IDX_T = 2'h3;
  localparam logic [7:0] REG_RST = 8'h00;
  // Core clock 25 MHz; transmit shift clock half period
  localparam int CLK_HZ       = 25_000_000;
  localparam int SCLK_HALF_NS = 160;
  localparam int SCLK_HALF_CYC =
    (SCLK_HALF_NS * (CLK_HZ / 1_000_000) / 1000) < 1 ? 1 :
    (SCLK_HALF_NS * (CLK_HZ / 1_000_000) / 1000);
  // Instruction codes presented to the block
  typedef enum logic [3:0] {
    SPRC_OP_NOP,
    SPRC_OP_LOAD_AB,
    SPRC_OP_LOAD_IMM,
    SPRC_OP_PORT_OUT,
    SPRC_OP_PORT_IN,
    SPRC_OP_READ_PIN,
    SPRC_OP_SET_DIR,
    SPRC_OP_SHIFT_INT,
    SPRC_OP_SEND,
    SPRC_OP_RECV,
    SPRC_OP_STOP
  } sprc_op_e;
  typedef enum logic [1:0] {SPRC_IDLE, SPRC_TX_LO, SPRC_TX_HI, SPRC_RX} sprc_state_e;
endpackage : sprc_pkg
`default_nettype wire

/* verilog/sprc_sync.sv */
// Two-flop synchroniser, vector wide.
// Assumes inputs come from outside the sys_clk domain.
`default_nettype none
module sprc_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  // First stage feeds only the second
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign sync_out = sync_q;
endmodule : sprc_sync
`default_nettype wire

/* verilog/sprc_chain.sv */
// The 32-bit general register chain with its four ports and serial link.
// Assumes the core issues one instruction per op_valid cycle on sys_clk.
`default_nettype none
module sprc_chain
  import sprc_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic             op_valid,
  input  wire logic [3:0]       op_code,
  input  wire logic [1:0]       op_sel,
  input  wire logic [NIB_W-1:0] acc_in,
  input  wire logic [NIB_W-1:0] aux_in,
  input  wire logic [REG_W-1:0] imm_in,
  input  wire logic             ctl_bit,
  input  wire logic             dir_out,
  input  wire logic             nib_hi,
  output logic                  busy,
  output logic [NIB_W-1:0]      acc_out,
  output logic [NIB_W-1:0]      aux_out,
  output logic                  acc_we,
  output logic                  aux_we,
  input  wire logic [REG_W-1:0] pq_i,
  output logic      [REG_W-1:0] pq_o,
  output logic      [REG_W-1:0] pq_oe,
  input  wire logic [REG_W-1:0] pr_i,
  output logic      [REG_W-1:0] pr_o,
  output logic      [REG_W-1:0] pr_oe,
  output logic      [REG_W-1:0] ps_o,
  output logic      [REG_W-1:0] pt_o,
  input  wire logic             data_i,
  output logic                  data_o,
  output logic                  data_oe,
  input  wire logic             sclk_i,
  output logic                  sclk_o,
  output logic                  sclk_oe
);
  sprc_op_e op;
  assign op = sprc_op_e'(op_code);

  // Pins from the outside world: two flops before use
  logic [REG_W-1:0] pq_s;
  logic [REG_W-1:0] pr_s;
  logic [1:0]       ser_s;
  sprc_sync #(.W(REG_W)) u_sq (.sys_clk(sys_clk), .arst_n(arst_n), .async_in(pq_i),
                               .sync_out(pq_s));
  sprc_sync #(.W(REG_W)) u_sr (.sys_clk(sys_clk), .arst_n(arst_n), .async_in(pr_i),
                               .sync_out(pr_s));
  sprc_sync #(.W(2)) u_ss (.sys_clk(sys_clk), .arst_n(arst_n),
                           .async_in({data_i, sclk_i}), .sync_out(ser_s));

  logic [REG_W-1:0] chain_q [NUM_REG];
  logic [REG_W-1:0] chain_d [NUM_REG];
  logic [REG_W-1:0] lat_q   [NUM_REG];
  logic [REG_W-1:0] lat_d   [NUM_REG];
  logic [1:0]       dir_q;
  logic [1:0]       dir_d;
  logic [1:0]       set_q;
  logic [1:0]       set_d;
  sprc_state_e      st_q;
  sprc_state_e      st_d;
  logic [7:0]       cnt_q;
  logic [7:0]       cnt_d;
  logic             ctl_q;
  logic             ctl_d;
  logic             sclk_prev_q;
  logic             sclk_prev_d;
  logic [REG_W-1:0] rdata_q;
  logic [REG_W-1:0] rdata_d;
  logic             rd_acc_q;
  logic             rd_acc_d;
  logic             rd_aux_q;
  logic             rd_aux_d;
  logic             shift;
  logic             shift_in;
  logic             rx_rise;

  assign rx_rise = ser_s[0] & ~sclk_prev_q;

  // Instruction decode, shifting and serial sequencing
  always_comb begin
    chain_d     = chain_q;
    lat_d       = lat_q;
    dir_d       = dir_q;
    set_d       = set_q;
    st_d        = st_q;
    cnt_d       = cnt_q;
    ctl_d       = ctl_q;
    sclk_prev_d = ser_s[0];
    rdata_d     = rdata_q;
    rd_acc_d    = 1'b0;
    rd_aux_d    = 1'b0;
    shift       = 1'b0;
    shift_in    = ctl_q;
    unique case (st_q)
      SPRC_IDLE: begin
        if (op_valid) begin
          unique case (op)
            SPRC_OP_LOAD_AB:  chain_d[op_sel] = {acc_in, aux_in};
            SPRC_OP_LOAD_IMM: chain_d[op_sel] = imm_in;
            // Whole byte to the latch in one step
            SPRC_OP_PORT_OUT: lat_d[op_sel] = chain_q[op_sel];
            SPRC_OP_PORT_IN: begin
              // Two-way ports read pins only once set to input
              if (op_sel == IDX_Q && set_q[0] && !dir_q[0]) chain_d[IDX_Q] = pq_s;
              else if (op_sel == IDX_R && set_q[1] && !dir_q[1]) chain_d[IDX_R] = pr_s;
              else if (op_sel == IDX_S || op_sel == IDX_T) begin
                chain_d[op_sel] = lat_q[op_sel];
              end
            end
            SPRC_OP_READ_PIN: begin
              if (op_sel == IDX_Q) begin
                rdata_d  = pq_s;
                rd_acc_d = 1'b1;
                rd_aux_d = 1'b1;
              end else begin
                rdata_d  = nib_hi ? {pr_s[7:4], pr_s[7:4]} : {pr_s[3:0], pr_s[3:0]};
                rd_aux_d = 1'b1;
              end
            end
            SPRC_OP_SET_DIR: begin
              dir_d[op_sel[0]] = dir_out;
              set_d[op_sel[0]] = 1'b1;
            end
            SPRC_OP_SHIFT_INT: begin
              shift    = 1'b1;
              shift_in = ctl_bit;
            end
            SPRC_OP_SEND: begin
              ctl_d = ctl_bit;
              cnt_d = 8'(op_sel) + 8'h01;
              st_d  = SPRC_TX_LO;
            end
            SPRC_OP_RECV: st_d = SPRC_RX;
            default: ;
          endcase
        end
      end
      SPRC_TX_LO: begin
        if (cnt_q == 8'(SCLK_HALF_CYC)) begin
          st_d  = SPRC_TX_HI;
          cnt_d = 8'h01;
        end else cnt_d = cnt_q + 8'h01;
      end
      SPRC_TX_HI: begin
        if (cnt_q == 8'(SCLK_HALF_CYC)) begin
          shift = 1'b1;
          cnt_d = 8'h01;
          st_d  = (op_valid && op == SPRC_OP_STOP) ? SPRC_IDLE : SPRC_TX_LO;
        end else cnt_d = cnt_q + 8'h01;
      end
      SPRC_RX: begin
        if (rx_rise) begin
          shift    = 1'b1;
          shift_in = ser_s[1];
        end
        if (op_valid && op == SPRC_OP_STOP) st_d = SPRC_IDLE;
      end
    endcase
    if (shift) begin
      chain_d[IDX_Q] = {shift_in, chain_q[IDX_Q][REG_W-1:1]};
      for (int i = 1; i < NUM_REG; i++) begin
        chain_d[i] = {chain_q[i-1][0], chain_q[i][REG_W-1:1]};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_REG; i++) begin
        chain_q[i] <= REG_RST;
        lat_q[i]   <= REG_RST;
      end
      dir_q       <= 2'h0;
      set_q       <= 2'h0;
      st_q        <= SPRC_IDLE;
      cnt_q       <= 8'h00;
      ctl_q       <= 1'b0;
      sclk_prev_q <= 1'b0;
      rdata_q     <= 8'h00;
      rd_acc_q    <= 1'b0;
      rd_aux_q    <= 1'b0;
    end else begin
      chain_q     <= chain_d;
      lat_q       <= lat_d;
      dir_q       <= dir_d;
      set_q       <= set_d;
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      ctl_q       <= ctl_d;
      sclk_prev_q <= sclk_prev_d;
      rdata_q     <= rdata_d;
      rd_acc_q    <= rd_acc_d;
      rd_aux_q    <= rd_aux_d;
    end
  end

  // Port pins follow their latches; two-way ports drive only in output mode
  assign pq_o    = lat_q[IDX_Q];
  assign pq_oe   = {REG_W{set_q[0] & dir_q[0]}};
  assign pr_o    = lat_q[IDX_R];
  assign pr_oe   = {REG_W{set_q[1] & dir_q[1]}};
  assign ps_o    = lat_q[IDX_S];
  assign pt_o    = lat_q[IDX_T];
  assign acc_out = rdata_q[REG_W-1:NIB_W];
  assign aux_out = rdata_q[NIB_W-1:0];
  assign acc_we  = rd_acc_q;
  assign aux_we  = rd_aux_q;
  // Serial link: float when idle, drive clock and data only while sending
  assign data_o  = chain_q[IDX_T][0];
  assign data_oe = (st_q == SPRC_TX_LO) || (st_q == SPRC_TX_HI);
  assign sclk_o  = (st_q == SPRC_TX_HI);
  assign sclk_oe = data_oe;
  assign busy    = (st_q != SPRC_IDLE);

  // Link idle float, one-bit advance per transmit pulse, and port, load, shift and read checks
  idle_float_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st_q == SPRC_IDLE) |-> (!sclk_oe && !data_oe)) else $error("link driven while idle");
  tx_shift_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st_q == SPRC_TX_HI && cnt_q == 8'(SCLK_HALF_CYC)) |=>
      chain_q[IDX_T][REG_W-1] == $past(chain_q[IDX_S][0])) else $error("chain not advanced");
  dir_gate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (|pq_oe) |-> set_q[0]) else $error("port driven before direction set");
  rx_entry_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st_q == SPRC_RX && rx_rise) |=> chain_q[IDX_Q][REG_W-1] == $past(ser_s[1]))
    else $error("received bit not at input-end msb");
  imm_load_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st_q == SPRC_IDLE && op_valid && op == SPRC_OP_LOAD_IMM) |=>
      chain_q[$past(op_sel)] == $past(imm_in)) else $error("immediate not loaded");
  port_out_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st_q == SPRC_IDLE && op_valid && op == SPRC_OP_PORT_OUT && op_sel == IDX_T) |=>
      pt_o == $past(chain_q[IDX_T])) else $error("port latch not updated");
  ctl_bit_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st_q == SPRC_IDLE && op_valid && op == SPRC_OP_SHIFT_INT) |=>
      chain_q[IDX_Q][REG_W-1] == $past(ctl_bit)) else $error("control bit lost");
  nib_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (st_q == SPRC_IDLE && op_valid && op == SPRC_OP_READ_PIN && op_sel == IDX_R) |=>
      aux_we && !acc_we) else $error("nibble read not to auxiliary");
endmodule : sprc_chain
`default_nettype wire

/* test/sprc_peer.sv */
// Peer serial logic on the far side of the DATA and shift-clock link.
// Assumes the bench resolves the shared pins from the device's enables.
`default_nettype none
module sprc_peer (
  input  wire logic        sclk_o,
  input  wire logic        sclk_oe,
  input  wire logic        data_o,
  output logic             sclk_p,
  output logic             data_p,
  output logic [31:0]      cap_q
);
  timeunit 1ns;
  timeprecision 1ns;

  // Clock stands still low between frames
  initial begin
    sclk_p = 1'b0;
    data_p = 1'b1;
    cap_q  = 32'h0;
  end

  // Take each sent bit on the device's own clock rise, first bit ends lowest
  always @(posedge sclk_o) begin
    if (sclk_oe) begin
      cap_q <= {data_o, cap_q[31:1]};
    end
  end

  // Supply a 320 ns clock with data set up half a period ahead of each rise
  task automatic send_word(input logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      data_p = w[i];
      #160 sclk_p = 1'b1;
      #160 sclk_p = 1'b0;
    end
    // Released line shows no stale level
    data_p = ~data_p;
  endtask : send_word
endmodule : sprc_peer
`default_nettype wire

/* test/serial_parallel_register_chain_tb_top.sv */
// Self-checking bench for the register chain: ports, shifting and serial link.
// Assumes the peer model of sprc_peer.sv and a 25 MHz core clock.
`default_nettype none
module serial_parallel_register_chain_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sprc_pkg::*;
  logic        sys_clk, arst_n, op_valid, ctl_bit, dir_out, nib_hi, busy, acc_we, aux_we;
  logic [3:0]  op_code, acc_out, aux_out, acc_in, aux_in;
  logic [1:0]  op_sel;
  logic [7:0]  imm_in, pq_i, pq_o, pq_oe, pr_i, pr_o, pr_oe, ps_o, pt_o, pq_drv, pr_drv;
  logic        data_i, data_o, data_oe, sclk_i, sclk_o, sclk_oe, sclk_p, data_p;
  logic [31:0] cap_q;
  int          fail_count, n_tests, rises;

  // Shared pins follow whoever drives them
  assign pq_i   = (pq_oe & pq_o) | (~pq_oe & pq_drv);
  assign pr_i   = (pr_oe & pr_o) | (~pr_oe & pr_drv);
  assign data_i = data_oe ? data_o : data_p;
  assign sclk_i = sclk_oe ? sclk_o : sclk_p;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sclk_o) rises++;

  sprc_chain dut_u (.sys_clk, .arst_n, .op_valid, .op_code, .op_sel, .acc_in, .aux_in,
    .imm_in, .ctl_bit, .dir_out, .nib_hi, .busy, .acc_out, .aux_out, .acc_we, .aux_we,
    .pq_i, .pq_o, .pq_oe, .pr_i, .pr_o, .pr_oe, .ps_o, .pt_o, .data_i, .data_o,
    .data_oe, .sclk_i, .sclk_o, .sclk_oe);
  sprc_peer peer_u (.sclk_o, .sclk_oe, .data_o, .sclk_p, .data_p, .cap_q);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One instruction per call; the low cycle after it keeps op_valid single-driven
  task automatic op(input sprc_op_e c, input logic [1:0] s);
    @(negedge sys_clk);
    op_valid = 1'b1;
    op_code  = c;
    op_sel   = s;
    @(negedge sys_clk);
    op_valid = 1'b0;
  endtask : op

  task automatic ld(input logic [1:0] s, input logic [7:0] v);
    imm_in = v;
    op(SPRC_OP_LOAD_IMM, s);
  endtask : ld

  // While sending, STOP is only seen at the end of a high phase, so it is held until the link idles
  task automatic stop_link();
    @(negedge sys_clk);
    op_valid = 1'b1;
    op_code  = SPRC_OP_STOP;
    op_sel   = 2'h0;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(negedge sys_clk);
    op_valid = 1'b0;
    if (busy !== 1'b0) begin
      fail_count++;
      finish_test();
    end
  endtask : stop_link

  task automatic t_ports();
    acc_in = 4'hC;
    aux_in = 4'h3;
    op(SPRC_OP_LOAD_AB, IDX_S);
    ld(IDX_T, 8'h5A);
    op(SPRC_OP_PORT_OUT, IDX_S);
    op(SPRC_OP_PORT_OUT, IDX_T);
    chk({ps_o, pt_o}, 16'hC35A);
    ld(IDX_S, 8'h00);
    op(SPRC_OP_PORT_IN, IDX_S);
    op(SPRC_OP_PORT_OUT, IDX_S);
    chk(ps_o, 8'hC3);
    for (int p = 0; p < 2; p++) begin
      dir_out = 1'b1;
      op(SPRC_OP_SET_DIR, 2'(p));
      ld(2'(p), 8'h96 + 8'(p));
      op(SPRC_OP_PORT_OUT, 2'(p));
      chk(p ? {pr_oe, pr_o} : {pq_oe, pq_o}, {8'hFF, 8'h96 + 8'(p)});
      dir_out = 1'b0;
      op(SPRC_OP_SET_DIR, 2'(p));
      chk(p ? pr_oe : pq_oe, 8'h00);
    end
  endtask : t_ports

  // Pins settle through the synchroniser before being read
  task automatic t_pins();
    pq_drv = 8'hA5;
    pr_drv = 8'h3C;
    repeat (3) @(negedge sys_clk);
    op(SPRC_OP_READ_PIN, IDX_Q);
    chk({acc_we, aux_we, acc_out, aux_out}, 10'h3A5);
    for (int h = 0; h < 2; h++) begin
      nib_hi = h[0];
      op(SPRC_OP_READ_PIN, IDX_R);
      chk({acc_we, aux_we, aux_out}, h ? 6'h13 : 6'h1C);
    end
    op(SPRC_OP_PORT_IN, IDX_Q);
    dir_out = 1'b1;
    op(SPRC_OP_SET_DIR, IDX_Q);
    op(SPRC_OP_PORT_OUT, IDX_Q);
    chk(pq_o, 8'hA5);
  endtask : t_pins

  task automatic t_shift();
    for (int i = 0; i < 4; i++) ld(2'(i), 8'(32'h01000100 >> (24 - 8 * i)));
    for (int c = 1; c >= 0; c--) begin
      ctl_bit = c[0];
      op(SPRC_OP_SHIFT_INT, IDX_Q);
      for (int i = 0; i < 4; i++) op(SPRC_OP_PORT_OUT, 2'(i));
      chk({pq_o, pr_o, ps_o, pt_o}, c ? 32'h80800080 : 32'h40400040);
    end
  endtask : t_shift

  task automatic t_link();
    ld(IDX_T, 8'hA5);
    rises = 0;
    op(SPRC_OP_SEND, 2'h0);
    for (int i = 0; i < 300 && rises < 8; i++) @(negedge sys_clk);
    chk(rises, 32'h8);
    if (rises < 8) finish_test();
    chk({busy, sclk_oe, data_oe}, 3'h7);
    stop_link();
    chk({cap_q[31:24], sclk_oe, data_oe}, {8'hA5, 2'h0});
    op(SPRC_OP_RECV, 2'h0);
    chk({busy, sclk_oe}, 2'h2);
    peer_u.send_word(32'h12345678);
    stop_link();
    for (int i = 0; i < 4; i++) op(SPRC_OP_PORT_OUT, 2'(i));
    chk({pq_o, pr_o, ps_o, pt_o}, 32'h12345678);
  endtask : t_link

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Main sequence: reset, then each scenario in turn
  initial begin
    {sys_clk, arst_n, op_valid, ctl_bit, dir_out, nib_hi} = '0;
    {op_code, op_sel, acc_in, aux_in, imm_in, pq_drv, pr_drv} = '0;
    repeat (20) @(negedge sys_clk);
    arst_n = 1'b1;
    chk({pq_oe, pr_oe, ps_o, pt_o}, 32'h0);
    chk({busy, sclk_oe, data_oe}, 3'h0);
    t_ports();
    t_pins();
    t_shift();
    t_link();
    finish_test();
  end
endmodule : serial_parallel_register_chain_tb_top
`default_nettype wire
